/* tesc_enc_model.sv */
// Quadrature encoder model that drives channel pins one and two.
// Assumes the bench pulses go for one cycle per step.
`timescale 1ns/10ps
module tesc_enc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Step commands
  input wire logic go,
  input wire logic rev,
  input wire logic both,
  // Encoder lines
  output logic pin_a,
  output logic pin_b
);
  logic [1:0] phase;

  // Gray walk so a normal step moves one line only
  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= 2'h0;
    end else if (go && both) begin
      phase <= phase + 2'h2; // Both lines flip at once on purpose
    end else if (go) begin
      phase <= rev ? phase - 2'h1 : phase + 2'h1;
    end
  end

  // Phases 0..3 give lines 00, 10, 11, 01
  assign pin_a = phase[1] ^ phase[0];
  assign pin_b = phase[1];
endmodule : tesc_enc_model

/* tesc_pkg.sv */
// Package for the timer encoder and slave control block.
// Holds register offsets, field positions, reset values and mode codes.
package tesc_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_SLAVE = 8'h08;
  localparam logic [7:0] OFS_IEN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CHCFG = 8'h18;
  localparam logic [7:0] OFS_CAPEN = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  localparam logic [7:0] OFS_RELOAD = 8'h2C;
  localparam logic [7:0] OFS_CMP1 = 8'h34;
  // Field positions
  localparam int CEN_BIT = 0;
  localparam int URS_BIT = 2;
  localparam int DIR_BIT = 4;
  localparam int XOR_BIT = 7;
  localparam int TIF_BIT = 6;
  localparam int UIF_BIT = 0;
  localparam int TIE_BIT = 6;
  localparam int P1_BIT = 1;
  localparam int P2_BIT = 5;
  localparam int SRC1_LSB = 0;
  localparam int F1_LSB = 4;
  localparam int SRC2_LSB = 8;
  localparam int F2_LSB = 12;
  localparam int TS_LSB = 4;
  // Reset values and field codes
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] FILT_OFF = 4'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  // Trigger source codes
  localparam logic [2:0] TS_IN1 = 3'h5;
  localparam logic [2:0] TS_IN2 = 3'h6;

  typedef enum logic [2:0] {
    SM_OFF = 3'b000,
    SM_ENC_B = 3'b001,
    SM_ENC_A = 3'b010,
    SM_ENC_AB = 3'b011,
    SM_RESET = 3'b100,
    SM_GATED = 3'b101,
    SM_TRIG = 3'b110,
    SM_EXT = 3'b111
  } tesc_mode_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tesc_bus_t;

  // Whole block state
  typedef struct packed {
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [15:0] slave;
    logic [15:0] ien;
    logic [15:0] chcfg;
    logic [15:0] capen;
    logic [15:0] count;
    logic [15:0] reload_pre;
    logic [15:0] reload_value;
    logic [15:0] cmp_pre;
    logic [15:0] compare_values;
    logic trigger_flag;
    logic update_flag;
    logic [2:0] pin1_s;
    logic [2:0] pin2_s;
    logic [2:0] pin3_s;
    logic [3:0] cnt_a;
    logic [3:0] cnt_b;
    logic fa;
    logic fb;
    logic pa;
    logic pb;
    logic gate_q;
    logic [15:0] rdata;
    logic irq;
    logic update_event;
  } tesc_state_t;
endpackage : tesc_pkg

/* tesc_timer.sv */
// Timer input control: encoder interface, input XOR, slave modes.
// Assumes channel pins are asynchronous; registers on a plain port.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/10ps
module tesc_timer
  import tesc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Channel pins
  input wire logic channel_pin_1,
  input wire logic channel_pin_2,
  input wire logic channel_pin_3,
  // Status outputs
  output logic [15:0] count,
  output logic count_down,
  output logic counter_enable,
  output logic trigger_flag,
  output logic update_event,
  output logic irq
);

  tesc_state_t q;
  tesc_state_t next_q;
  tesc_bus_t bus;

  // Filter: input must hold for filter-field plus one cycles before passing
  function automatic logic [4:0] filt_step(input logic [3:0] cnt,
      input logic cur, input logic raw, input logic [3:0] len);
    logic [3:0] c;
    logic o;
    c = cnt;
    o = cur;
    if (len == FILT_OFF) begin
      o = raw;
      c = 4'h0;
    end else if (raw == cur) begin
      c = 4'h0;
    end else if (c >= len) begin
      o = raw;
      c = 4'h0;
    end else begin
      c = c + 4'h1;
    end
    filt_step = {c, o};
  endfunction : filt_step

  logic raw1;
  logic raw2;
  logic [4:0] f1;
  logic [4:0] f2;
  logic in_a;
  logic in_b;
  logic ch_a;
  logic ch_b;
  logic ea;
  logic eb;
  logic trig_lvl;
  logic trig_edge;
  logic tick;
  logic dn;
  logic wrap;
  logic do_upd;
  logic is_enc;
  logic en;
  logic tset;
  tesc_mode_t mode;
  logic [2:0] tsel;

  always_comb begin
    bus.addr = addr;
    bus.wdata = wdata;
    bus.wr = wr;
    bus.rd = rd;
  end

  // Next-state logic
  always_comb begin
    next_q = q;
    mode = tesc_mode_t'(q.slave[2:0]);
    tsel = q.slave[TS_LSB +: 3];
    // Two-stage sync on every pin, only stage 2 read onward
    next_q.pin1_s = {q.pin1_s[1:0], channel_pin_1};
    next_q.pin2_s = {q.pin2_s[1:0], channel_pin_2};
    next_q.pin3_s = {q.pin3_s[1:0], channel_pin_3};
    // Channel one input, XOR of three pins when selected
    raw1 = q.ctrl2[XOR_BIT] ?
        (q.pin1_s[1] ^ q.pin2_s[1] ^ q.pin3_s[1]) : q.pin1_s[1];
    raw2 = q.pin2_s[1];
    f1 = filt_step(q.cnt_a, q.fa, raw1, q.chcfg[F1_LSB +: 4]);
    f2 = filt_step(q.cnt_b, q.fb, raw2, q.chcfg[F2_LSB +: 4]);
    next_q.cnt_a = f1[4:1];
    next_q.fa = f1[0];
    next_q.cnt_b = f2[4:1];
    next_q.fb = f2[0];
    // Polarity inversion after the filter
    in_a = q.fa ^ q.capen[P1_BIT];
    in_b = q.fb ^ q.capen[P2_BIT];
    next_q.pa = in_a;
    next_q.pb = in_b;
    // Channel routed only when source select is 01
    ch_a = (q.chcfg[SRC1_LSB +: 2] == SRC_PIN) ? in_a : 1'b0;
    ch_b = (q.chcfg[SRC2_LSB +: 2] == SRC_PIN) ? in_b : 1'b0;
    ea = (in_a != q.pa);
    eb = (in_b != q.pb);
    // Trigger selection, no capture prescaler in path
    if (tsel == TS_IN1) begin
      trig_lvl = ch_a;
    end else if (tsel == TS_IN2) begin
      trig_lvl = ch_b;
    end else begin
      trig_lvl = 1'b0;
    end
    trig_edge = trig_lvl & ~q.gate_q;
    next_q.gate_q = trig_lvl;
    is_enc = (mode == SM_ENC_A) || (mode == SM_ENC_B)
        || (mode == SM_ENC_AB);
    en = q.ctrl1[CEN_BIT];
    dn = q.ctrl1[DIR_BIT];
    tick = 1'b0;
    do_upd = 1'b0;
    next_q.trigger_flag = q.trigger_flag;
    tset = 1'b0; // Hardware set of the trigger flag this cycle
    // Encoder decode; equal-cycle changes ignored
    if (is_enc && (ea ^ eb)) begin
      if (ea) begin
        dn = in_a ? in_b : ~in_b;
        tick = (mode != SM_ENC_B);
      end else begin
        dn = in_b ? ~in_a : in_a;
        tick = (mode != SM_ENC_A);
      end
      next_q.ctrl1[DIR_BIT] = dn;
    end else if (!is_enc) begin
      tick = 1'b1;
    end
    // Slave modes
    if (mode == SM_GATED) begin
      tick = trig_lvl;
      if (en && (trig_lvl != q.gate_q)) begin
        next_q.trigger_flag = 1'b1;
        tset = 1'b1;
      end
    end
    if (mode == SM_TRIG && trig_edge && !en) begin
      next_q.ctrl1[CEN_BIT] = 1'b1;
      next_q.trigger_flag = 1'b1;
      tset = 1'b1;
    end
    // Counter advance only when enabled
    wrap = 1'b0;
    if (en && tick) begin
      if (dn) begin
        wrap = (q.count == 16'h0000);
        next_q.count = wrap ? q.reload_value : q.count - 16'h0001;
      end else begin
        wrap = (q.count >= q.reload_value);
        next_q.count = wrap ? 16'h0000 : q.count + 16'h0001;
      end
    end
    do_upd = wrap;
    // Reset mode: clear counter on trigger
    if (mode == SM_RESET && trig_edge) begin
      next_q.count = 16'h0000;
      next_q.trigger_flag = 1'b1;
      tset = 1'b1;
      if (!q.ctrl1[URS_BIT]) begin
        do_upd = 1'b1;
      end
    end
    // Update event transfers preloads
    if (do_upd) begin
      next_q.reload_value = q.reload_pre;
      next_q.compare_values = q.cmp_pre;
      next_q.update_flag = 1'b1;
    end
    next_q.update_event = do_upd;
    // Register writes; hardware set wins over clear
    if (bus.wr) begin
      if (bus.addr == OFS_CTRL1) begin
        next_q.ctrl1 = bus.wdata;
        if (mode == SM_TRIG && trig_edge && !en) begin
          next_q.ctrl1[CEN_BIT] = 1'b1;
        end
      end else if (bus.addr == OFS_CTRL2) begin
        next_q.ctrl2 = bus.wdata;
      end else if (bus.addr == OFS_SLAVE) begin
        next_q.slave = bus.wdata;
      end else if (bus.addr == OFS_IEN) begin
        next_q.ien = bus.wdata;
      end else if (bus.addr == OFS_STATUS) begin
        // Write 0 clears; a set in the same cycle still wins
        next_q.trigger_flag = (q.trigger_flag & bus.wdata[TIF_BIT])
            | tset;
        next_q.update_flag = (q.update_flag & bus.wdata[UIF_BIT])
            | do_upd;
      end else if (bus.addr == OFS_CHCFG) begin
        next_q.chcfg = bus.wdata;
      end else if (bus.addr == OFS_CAPEN) begin
        next_q.capen = bus.wdata;
      end else if (bus.addr == OFS_COUNT) begin
        next_q.count = bus.wdata;
      end else if (bus.addr == OFS_RELOAD) begin
        next_q.reload_pre = bus.wdata;
      end else if (bus.addr == OFS_CMP1) begin
        next_q.cmp_pre = bus.wdata;
      end
    end
    // Read data, one cycle after the strobe
    next_q.rdata = 16'h0000;
    if (bus.rd) begin
      if (bus.addr == OFS_CTRL1) begin
        next_q.rdata = q.ctrl1;
      end else if (bus.addr == OFS_CTRL2) begin
        next_q.rdata = q.ctrl2;
      end else if (bus.addr == OFS_SLAVE) begin
        next_q.rdata = q.slave;
      end else if (bus.addr == OFS_IEN) begin
        next_q.rdata = q.ien;
      end else if (bus.addr == OFS_STATUS) begin
        next_q.rdata[TIF_BIT] = q.trigger_flag;
        next_q.rdata[UIF_BIT] = q.update_flag;
      end else if (bus.addr == OFS_CHCFG) begin
        next_q.rdata = q.chcfg;
      end else if (bus.addr == OFS_CAPEN) begin
        next_q.rdata = q.capen;
      end else if (bus.addr == OFS_COUNT) begin
        next_q.rdata = q.count;
      end else if (bus.addr == OFS_RELOAD) begin
        next_q.rdata = q.reload_pre;
      end else if (bus.addr == OFS_CMP1) begin
        next_q.rdata = q.cmp_pre;
      end
    end
    // Trigger interrupt request
    next_q.irq = next_q.trigger_flag & q.ien[TIE_BIT];
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0; // All registers reset to zero
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from flip-flops
  assign rdata = q.rdata;
  assign count = q.count;
  assign count_down = q.ctrl1[DIR_BIT];
  assign counter_enable = q.ctrl1[CEN_BIT];
  assign trigger_flag = q.trigger_flag;
  assign update_event = q.update_event;
  assign irq = q.irq;

  // Reset trigger clears count next cycle
  reset_clear_a: assert property (@(posedge clk) disable iff (srst)
      (mode == SM_RESET && trig_edge && !wr) |=> (q.count == 16'h0000))
    else $error("count not cleared by reset trigger");
  reset_flag_a: assert property (@(posedge clk) disable iff (srst)
      (mode == SM_RESET && trig_edge) |=> q.trigger_flag)
    else $error("trigger flag not set on reset trigger");
  reset_upd_a: assert property (@(posedge clk) disable iff (srst)
      (mode == SM_RESET && trig_edge && !q.ctrl1[URS_BIT])
      |=> q.update_event)
    else $error("no update on reset trigger");
  gate_hold_a: assert property (@(posedge clk) disable iff (srst)
      (!en && !wr && !(mode == SM_RESET && trig_edge))
      |=> (q.count == $past(q.count)))
    else $error("counter moved while disabled");
  gated_stop_a: assert property (@(posedge clk) disable iff (srst)
      (mode == SM_GATED && !trig_lvl && !wr) |=> $stable(q.count))
    else $error("gated counter moved with gate closed");
  trig_start_a: assert property (@(posedge clk) disable iff (srst)
      (mode == SM_TRIG && trig_edge && !en)
      |=> (q.ctrl1[CEN_BIT] && q.trigger_flag))
    else $error("trigger mode did not start counter");
  enc_both_a: assert property (@(posedge clk) disable iff (srst)
      (is_enc && ea && eb && !wr)
      |=> ($stable(q.count) && $stable(q.ctrl1[DIR_BIT])))
    else $error("simultaneous edges changed count");
  enc_range_a: assert property (@(posedge clk) disable iff (srst)
      (is_enc && en && tick && !dn && q.count == q.reload_value && !wr)
      |=> (q.count == 16'h0000 && q.update_event))
    else $error("encoder up wrap wrong");
  enc_bonly_a: assert property (@(posedge clk) disable iff (srst)
      (mode == SM_ENC_B && ea && !eb && !wr) |=> $stable(q.count))
    else $error("input A counted in B-only mode");
  enc_aonly_a: assert property (@(posedge clk) disable iff (srst)
      (mode == SM_ENC_A && eb && !ea && !wr) |=> $stable(q.count))
    else $error("input B counted in A-only mode");
  // Direction from the level of the other input
  dir_from_a_a: assert property (@(posedge clk) disable iff (srst)
      (is_enc && ea && !eb && !wr)
      |=> (q.ctrl1[DIR_BIT] == ($past(in_a) == $past(in_b))))
    else $error("wrong direction on input A edge");
  dir_from_b_a: assert property (@(posedge clk) disable iff (srst)
      (is_enc && eb && !ea && !wr)
      |=> (q.ctrl1[DIR_BIT] == ($past(in_a) != $past(in_b))))
    else $error("wrong direction on input B edge");
  dir_hold_a: assert property (@(posedge clk) disable iff (srst)
      (is_enc && !ea && !eb && !wr) |=> $stable(q.ctrl1[DIR_BIT]))
    else $error("direction changed without input edge");
  // Down wrap reloads and raises the update event
  down_wrap_a: assert property (@(posedge clk) disable iff (srst)
      (is_enc && en && tick && dn && q.count == 16'h0000 && !wr
      && mode != SM_RESET)
      |=> (q.count == $past(q.reload_value) && q.update_event))
    else $error("encoder down wrap wrong");
  gated_flag_a: assert property (@(posedge clk) disable iff (srst)
      (mode == SM_GATED && en && trig_lvl != q.gate_q) |=> q.trigger_flag)
    else $error("gate change did not set trigger flag");
  // Interrupt follows flag and enable
  irq_track_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=> (q.irq == (q.trigger_flag & $past(q.ien[TIE_BIT]))))
    else $error("interrupt request does not follow flag");
  // Read data stand only in the cycle after a read strobe
  rdata_idle_a: assert property (@(posedge clk) disable iff (srst)
      !rd |=> (q.rdata == 16'h0000))
    else $error("read data present without read strobe");
endmodule : tesc_timer

/* tesc_timer_tb_top.sv */
// Self-checking bench for the timer input control block.
// Assumes the encoder model on pins one and two, pin three from here.
`timescale 1ns/10ps
module tesc_timer_tb_top;
  import tesc_pkg::*;
  typedef struct packed {
    logic [2:0] m;
    logic r, p, e, b, d;
    logic [15:0] s, x;
  } tesc_row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic rev = 1'b0;
  logic both = 1'b0;
  logic pin3 = 1'b0;
  logic pin1, pin2, cd, ce, tf, ue, irq;
  logic [15:0] rdata, cnt, q, c1;
  int n_errors = 0;
  int checks_done = 0;
  // Mode, reverse, invert A, enable, both, down, start, result
  tesc_row_t rows [11] = '{
    '{3'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 16'h5, 16'h7},
    '{3'h2, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 16'h5, 16'h7},
    '{3'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 16'h5, 16'h9},
    '{3'h3, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 16'h5, 16'h1},
    '{3'h2, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 16'h5, 16'h3},
    '{3'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 16'h5, 16'h3},
    '{3'h3, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 16'h5, 16'h1},
    '{3'h3, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 16'h1, 16'h8},
    '{3'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 16'h9, 16'h2},
    '{3'h3, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 16'h5, 16'h5},
    '{3'h3, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 16'h5, 16'h5}};

  // Clock at 100 MHz
  always #5 clk = ~clk;

  tesc_timer dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .channel_pin_1(pin1),
    .channel_pin_2(pin2), .channel_pin_3(pin3), .count(cnt),
    .count_down(cd), .counter_enable(ce), .trigger_flag(tf),
    .update_event(ue), .irq(irq));

  tesc_enc_model enc (.clk(clk), .srst(srst), .go(go), .rev(rev),
    .both(both), .pin_a(pin1), .pin_b(pin2));

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // One write cycle, then one idle edge
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  // One read cycle, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
    @(posedge clk);
  endtask : rd_reg

  // One encoder step, then time for the input pipeline
  task automatic step(input logic r, input logic b);
    rev <= r;
    both <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : step

  // Two reads two cycles apart: running wraps modulo reload plus one
  task automatic rate(input logic k);
    rd_reg(OFS_COUNT);
    c1 = q;
    rd_reg(OFS_COUNT);
    chk(q, k ? (c1 + 16'h2) % 16'hB : c1);
  endtask : rate

  // Counts and verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(cnt, RST_WORD);
    chk({12'h0, ce, tf, irq, cd}, 16'h0000);
    wr_reg(8'h14, 16'hFFFF);
    rd_reg(8'h14);
    chk(q, 16'h0000);
    rd_reg(OFS_CTRL1);
    chk(q, RST_WORD);
    $display("done reset");
    wr_reg(OFS_RELOAD, 16'h000A);
    wr_reg(OFS_IEN, 16'h0040);
    wr_reg(OFS_CHCFG, 16'h0101);
    wr_reg(OFS_SLAVE, 16'h0054);
    wr_reg(OFS_CTRL1, 16'h0001);
    step(1'b0, 1'b0);
    chk({14'h0, tf, irq}, 16'h0003);
    rd_reg(OFS_COUNT);
    chk({15'h0, q <= 16'h000A}, 16'h0001);
    repeat (3) step(1'b0, 1'b0);
    wr_reg(OFS_CTRL1, 16'h0000);
    wr_reg(OFS_STATUS, 16'h0000);
    $display("done reset mode");
    foreach (rows[i]) begin
      wr_reg(OFS_CAPEN, {14'h0, rows[i].p, 1'h0});
      repeat (8) @(posedge clk);
      wr_reg(OFS_SLAVE, {13'h0, rows[i].m});
      wr_reg(OFS_COUNT, rows[i].s);
      wr_reg(OFS_CTRL1, {15'h0, rows[i].e});
      repeat (4) step(rows[i].r, rows[i].b);
      rd_reg(OFS_COUNT);
      chk(q, rows[i].x);
      if (rows[i].e) chk({15'h0, cd}, {15'h0, rows[i].d});
      wr_reg(OFS_CTRL1, 16'h0000);
    end
    $display("done encoder rows");
    wr_reg(OFS_CTRL2, 16'h0080);
    wr_reg(OFS_SLAVE, 16'h0055);
    wr_reg(OFS_COUNT, 16'h0000);
    wr_reg(OFS_CTRL1, 16'h0001);
    rate(1'b0);
    chk({15'h0, tf}, 16'h0000);
    pin3 <= 1'b1;
    repeat (8) @(posedge clk);
    chk({15'h0, tf}, 16'h0001);
    rate(1'b1);
    wr_reg(OFS_STATUS, 16'h0000);
    pin3 <= 1'b0;
    repeat (8) @(posedge clk);
    chk({15'h0, tf}, 16'h0001);
    rate(1'b0);
    wr_reg(OFS_CTRL1, 16'h0000);
    pin3 <= 1'b1;
    repeat (8) @(posedge clk);
    rate(1'b0);
    $display("done gated mode");
    wr_reg(OFS_CTRL2, 16'h0000);
    wr_reg(OFS_SLAVE, 16'h0066);
    repeat (8) @(posedge clk);
    wr_reg(OFS_STATUS, 16'h0000);
    chk({14'h0, ce, tf}, 16'h0000);
    repeat (4) step(1'b0, 1'b0);
    chk({14'h0, ce, tf}, 16'h0003);
    rate(1'b1);
    $display("done trigger mode");
    close_out();
  end

  // Cut a hung run short
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule : tesc_timer_tb_top
